/* File: rtl/tevg_chan.sv */
`timescale 1ns/1ps
module tevg_chan import tevg_pkg::*; (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Event and configuration.
  input  wire logic        force_evt,
  input  wire logic        is_input,
  input  wire logic [15:0] cnt,
  input  wire logic        clr_flag,
  input  wire logic        clr_oc,
  // Channel state.
  output logic             flag,
  output logic             oc,
  output logic      [15:0] cap
);

  tevg_chan_st_t st;
  tevg_chan_st_t next_st;

  // Clears first, so a forced event in the same cycle wins.
  always_comb begin
    next_st = st;
    if (clr_flag) begin
      next_st.flag = 1'h0;
    end
    if (clr_oc) begin
      next_st.oc = 1'h0;
    end
    if (force_evt) begin
      next_st.flag = 1'h1;
      if (is_input) begin
        next_st.cap = cnt;
        if (st.flag) begin
          next_st.oc = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;
  assign oc   = st.oc;
  assign cap  = st.cap;

  chk_out_nocap: assert property (@(posedge pclk) disable iff (!presetn)
    force_evt && !is_input |=> st.flag && $stable(st.cap))
    else $error("output-mode forced event touched capture value");
  chk_in_capture: assert property (@(posedge pclk) disable iff (!presetn)
    force_evt && is_input |=> st.flag && (st.cap == $past(cnt)))
    else $error("input-mode forced event did not capture counter");
  chk_overcapture: assert property (@(posedge pclk) disable iff (!presetn)
    force_evt && is_input && st.flag |=> st.oc)
    else $error("overcapture flag not set on repeated capture");

endmodule : tevg_chan

/* File: rtl/tevg_cnt.sv */
`timescale 1ns/1ps
`include "tevg_map.svh"
module tevg_cnt import tevg_pkg::*; (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control.
  input  wire logic        enable,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] psc,
  input  wire logic [15:0] arr,
  input  wire logic        force_upd,
  // Count state.
  output logic      [15:0] cnt,
  output logic      [15:0] psc_cnt,
  output logic             ovf
);

  tevg_cnt_st_t st;
  tevg_cnt_st_t next_st;

  // A forced update overrides counting in the same cycle.
  always_comb begin
    next_st = st;
    next_st.ovf = 1'h0;
    if (force_upd) begin
      next_st.psc_cnt = 16'h0000;
      next_st.down = (mode == `TEVG_MODE_DOWN);
      next_st.cnt = (mode == `TEVG_MODE_DOWN) ? arr : 16'h0000;
    end else if (enable) begin
      if (st.psc_cnt >= psc) begin
        next_st.psc_cnt = 16'h0000;
        case (mode)
          `TEVG_MODE_UP: begin
            next_st.down = 1'h0;
            if (st.cnt >= arr) begin
              next_st.cnt = 16'h0000;
              next_st.ovf = 1'h1;
            end else begin
              next_st.cnt = st.cnt + 16'h0001;
            end
          end
          `TEVG_MODE_DOWN: begin
            next_st.down = 1'h1;
            if (st.cnt == 16'h0000) begin
              next_st.cnt = arr;
              next_st.ovf = 1'h1;
            end else begin
              next_st.cnt = st.cnt - 16'h0001;
            end
          end
          default: begin
            // Centre-aligned: turn round at the reload value and at zero.
            if (!st.down) begin
              if (st.cnt >= arr) begin
                next_st.down = 1'h1;
                next_st.cnt = st.cnt - 16'h0001;
                next_st.ovf = 1'h1;
              end else begin
                next_st.cnt = st.cnt + 16'h0001;
              end
            end else if (st.cnt == 16'h0000) begin
              next_st.down = 1'h0;
              next_st.cnt = 16'h0001;
              next_st.ovf = 1'h1;
            end else begin
              next_st.cnt = st.cnt - 16'h0001;
            end
          end
        endcase
      end else begin
        next_st.psc_cnt = st.psc_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cnt     = st.cnt;
  assign psc_cnt = st.psc_cnt;
  assign ovf     = st.ovf;

  chk_psc_restart: assert property (@(posedge pclk) disable iff (!presetn)
    force_upd |=> (st.psc_cnt == 16'h0000) && $stable(psc))
    else $error("prescaler counter not cleared by forced update");
  chk_up_clear: assert property (@(posedge pclk) disable iff (!presetn)
    force_upd && (mode != `TEVG_MODE_DOWN) |=> st.cnt == 16'h0000)
    else $error("counter not cleared by forced update");
  chk_down_reload: assert property (@(posedge pclk) disable iff (!presetn)
    force_upd && (mode == `TEVG_MODE_DOWN) |=> st.cnt == $past(arr))
    else $error("counter not loaded with reload value");

endmodule : tevg_cnt

/* File: rtl/tevg_map.svh */
`ifndef TEVG_MAP_SVH
`define TEVG_MAP_SVH

// Register byte offsets on the APB bus.
`define TEVG_OFF_CTRL     8'h00
`define TEVG_OFF_STATUS   8'h04
`define TEVG_OFF_MASK     8'h08
`define TEVG_OFF_DMA      8'h0C
`define TEVG_OFF_CHDIR    8'h10
`define TEVG_OFF_SWEV     8'h14
`define TEVG_OFF_CNT      8'h24
`define TEVG_OFF_PSC      8'h28
`define TEVG_OFF_ARR      8'h2C
`define TEVG_OFF_CAP1     8'h34
`define TEVG_OFF_CAP2     8'h38
`define TEVG_OFF_CAP3     8'h3C
`define TEVG_OFF_CAP4     8'h40

// Bit positions shared by the event, status, mask and DMA registers; the overcapture bit is in status and mask only.
`define TEVG_BIT_UPD      0
`define TEVG_BIT_CH1      1
`define TEVG_BIT_TRG      6
`define TEVG_BIT_OC1      9

// Control register fields.
`define TEVG_CTRL_CEN     0
`define TEVG_CTRL_MODE    1
`define TEVG_CTRL_UPDATE_DISABLE_CONTROL    3
`define TEVG_CTRL_URS     4

// Count direction codes.
`define TEVG_MODE_UP      2'h0
`define TEVG_MODE_DOWN    2'h1

// Writable bit masks and reset values.
`define TEVG_SWEV_BITS    7'h5F
`define TEVG_STAT_BITS    16'h1E5F
`define TEVG_RST_ARR      16'hFFFF
`define TEVG_RST_PSC      16'h0000

`endif

/* File: rtl/tevg_pkg.sv */
package tevg_pkg;

  // State of the counter core.
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] psc_cnt;
    logic        down;
    logic        ovf;
  } tevg_cnt_st_t;

  // State of one compare/capture channel.
  typedef struct packed {
    logic        flag;
    logic        oc;
    logic [15:0] cap;
  } tevg_chan_st_t;

  // State of the register file and event logic.
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] mask;
    logic [6:0]  dma_en;
    logic [3:0]  chdir;
    logic [6:0]  swev;
    logic [15:0] psc;
    logic [15:0] arr;
    logic        update_event_flag;
    logic        trigger_event_flag;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic [6:0]  dma_req;
    logic        trig_out;
    logic        upd_out;
  } tevg_top_st_t;

endpackage : tevg_pkg

/* File: rtl/tevg_top.sv */
`timescale 1ns/1ps
`include "tevg_map.svh"
module tevg_top import tevg_pkg::*; (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt and DMA requests.
  output logic             irq,
  output logic      [6:0]  dma_req,
  // Event pulses to the rest of the timer.
  output logic             trig_out,
  output logic             upd_out
);

  tevg_top_st_t st;
  tevg_top_st_t next_st;

  logic [15:0] cnt;
  logic [15:0] psc_cnt;
  logic        ovf;
  logic [3:0]  chan_flag;
  logic [3:0]  chan_oc;
  logic [15:0] cap [4];
  logic [3:0]  clr_flag;
  logic [3:0]  clr_oc;
  logic [15:0] status_vec;
  logic        setup;
  logic        wr_done;
  logic        rd_done;
  logic        update_disable_control;
  logic        update_request_source_select;
  logic        irq_src;

  // Bus phases; a write commits only at the completing access edge.
  assign setup   = psel && !penable;
  assign wr_done = psel && penable && st.pready && pwrite;
  assign rd_done = psel && penable && st.pready && !pwrite;
  assign update_disable_control    = st.ctrl[`TEVG_CTRL_UPDATE_DISABLE_CONTROL];
  assign update_request_source_select     = st.ctrl[`TEVG_CTRL_URS];

  // Status layout: update, four channel flags, trigger, four overcaptures.
  assign status_vec = {3'h0, chan_oc, 2'h0, st.trigger_event_flag, 1'h0, chan_flag, st.update_event_flag};

  // Any set status bit that software has unmasked asks for the interrupt.
  assign irq_src = |(status_vec & st.mask);

  // Counter core; the forced update comes straight from the pending bit.
  tevg_cnt i_tevg_cnt (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (st.ctrl[`TEVG_CTRL_CEN]),
    .mode      (st.ctrl[`TEVG_CTRL_MODE +: 2]),
    .psc       (st.psc),
    .arr       (st.arr),
    .force_upd (st.swev[`TEVG_BIT_UPD]),
    .cnt       (cnt),
    .psc_cnt   (psc_cnt),
    .ovf       (ovf)
  );

  // One channel per channel force bit; reading an input capture value clears its flag.
  for (genvar k = 0; k < 4; k++) begin : g_chan
    assign clr_flag[k] = (wr_done && (paddr == `TEVG_OFF_STATUS) && pwdata[`TEVG_BIT_CH1 + k])
                       || (rd_done && (paddr == `TEVG_OFF_CAP1 + 8'(4 * k)) && st.chdir[k]);
    assign clr_oc[k]   = wr_done && (paddr == `TEVG_OFF_STATUS) && pwdata[`TEVG_BIT_OC1 + k];
    tevg_chan i_tevg_chan (
      .pclk      (pclk),
      .presetn   (presetn),
      .force_evt (st.swev[`TEVG_BIT_CH1 + k]),
      .is_input  (st.chdir[k]),
      .cnt       (cnt),
      .clr_flag  (clr_flag[k]),
      .clr_oc    (clr_oc[k]),
      .flag      (chan_flag[k]),
      .oc        (chan_oc[k]),
      .cap       (cap[k])
    );
    // Every channel force sets its flag and pulses its DMA request as enabled.
    chk_chan_flag: assert property (@(posedge pclk) disable iff (!presetn)
      st.swev[`TEVG_BIT_CH1 + k] |=> chan_flag[k])
      else $error("channel force did not set its flag");
    chk_chan_dma: assert property (@(posedge pclk) disable iff (!presetn)
      st.swev[`TEVG_BIT_CH1 + k] |=> st.dma_req[`TEVG_BIT_CH1 + k] == $past(st.dma_en[`TEVG_BIT_CH1 + k]))
      else $error("channel force did not follow its DMA enable");
  end

  // Register file, self-clearing force bits and event flags.
  always_comb begin
    next_st = st;
    next_st.swev     = 7'h00;
    next_st.pready   = 1'h0;
    next_st.pslverr  = 1'h0;
    next_st.dma_req  = 7'h00;
    next_st.trig_out = 1'h0;
    next_st.upd_out  = 1'h0;

    // Read data and the answer are prepared in the setup cycle.
    if (setup) begin
      next_st.pready = 1'h1;
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        `TEVG_OFF_CTRL: begin
          next_st.prdata = {27'h0, st.ctrl};
        end
        `TEVG_OFF_STATUS: begin
          next_st.prdata = {16'h0, status_vec};
        end
        `TEVG_OFF_MASK: begin
          next_st.prdata = {16'h0, st.mask};
        end
        `TEVG_OFF_DMA: begin
          next_st.prdata = {25'h0, st.dma_en};
        end
        `TEVG_OFF_CHDIR: begin
          next_st.prdata = {28'h0, st.chdir};
        end
        `TEVG_OFF_SWEV: begin
          next_st.prdata = 32'h0000_0000;
        end
        `TEVG_OFF_CNT: begin
          next_st.prdata = {16'h0, cnt};
        end
        `TEVG_OFF_PSC: begin
          next_st.prdata = {16'h0, st.psc};
        end
        `TEVG_OFF_ARR: begin
          next_st.prdata = {16'h0, st.arr};
        end
        `TEVG_OFF_CAP1: begin
          next_st.prdata = {16'h0, cap[0]};
        end
        `TEVG_OFF_CAP2: begin
          next_st.prdata = {16'h0, cap[1]};
        end
        `TEVG_OFF_CAP3: begin
          next_st.prdata = {16'h0, cap[2]};
        end
        `TEVG_OFF_CAP4: begin
          next_st.prdata = {16'h0, cap[3]};
        end
        default: begin
          next_st.pslverr = 1'h1;
        end
      endcase
    end

    // Writes; the counter and capture values are read-only and ignore them.
    if (wr_done) begin
      case (paddr)
        `TEVG_OFF_CTRL: begin
          next_st.ctrl = pwdata[4:0];
        end
        `TEVG_OFF_STATUS: begin
          if (pwdata[`TEVG_BIT_UPD]) begin
            next_st.update_event_flag = 1'h0;
          end
          if (pwdata[`TEVG_BIT_TRG]) begin
            next_st.trigger_event_flag = 1'h0;
          end
        end
        `TEVG_OFF_MASK: begin
          next_st.mask = pwdata[15:0] & `TEVG_STAT_BITS;
        end
        `TEVG_OFF_DMA: begin
          next_st.dma_en = pwdata[6:0] & `TEVG_SWEV_BITS;
        end
        `TEVG_OFF_CHDIR: begin
          next_st.chdir = pwdata[3:0];
        end
        `TEVG_OFF_SWEV: begin
          // Only ones request events; zeros and reserved bits are dropped.
          next_st.swev = pwdata[6:0] & `TEVG_SWEV_BITS;
        end
        `TEVG_OFF_PSC: begin
          next_st.psc = pwdata[15:0];
        end
        `TEVG_OFF_ARR: begin
          next_st.arr = pwdata[15:0];
        end
        default: begin
          next_st.ctrl = st.ctrl;
        end
      endcase
    end

    // Trigger event; setting after the clear makes a same-cycle event win.
    if (st.swev[`TEVG_BIT_TRG]) begin
      next_st.trigger_event_flag = 1'h1;
      next_st.trig_out = 1'h1;
      next_st.dma_req[`TEVG_BIT_TRG] = st.dma_en[`TEVG_BIT_TRG];
    end

    // Channel DMA requests follow their force pulses.
    next_st.dma_req[4:1] = st.swev[4:1] & st.dma_en[4:1];

    // Update event: forced one gated by both controls, overflow by disable only.
    if ((st.swev[`TEVG_BIT_UPD] && !update_request_source_select && !update_disable_control) || (ovf && !update_disable_control)) begin
      next_st.update_event_flag = 1'h1;
      next_st.upd_out = 1'h1;
      next_st.dma_req[`TEVG_BIT_UPD] = st.dma_en[`TEVG_BIT_UPD];
    end

    // Level interrupt lags the status bits by one cycle to stay registered.
    next_st.irq = irq_src;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st     <= '0;
      st.arr <= `TEVG_RST_ARR;
      st.psc <= `TEVG_RST_PSC;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign irq      = st.irq;
  assign dma_req  = st.dma_req;
  assign trig_out = st.trig_out;
  assign upd_out  = st.upd_out;

  chk_trig_oneshot: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && (paddr == `TEVG_OFF_SWEV) && pwdata[`TEVG_BIT_TRG]
    |=> st.swev[`TEVG_BIT_TRG] ##1 !st.swev[`TEVG_BIT_TRG])
    else $error("trigger force bit did not clear itself");
  chk_trig_effect: assert property (@(posedge pclk) disable iff (!presetn)
    st.swev[`TEVG_BIT_TRG] |=> st.trigger_event_flag && st.trig_out
    && (st.dma_req[`TEVG_BIT_TRG] == $past(st.dma_en[`TEVG_BIT_TRG])))
    else $error("trigger force did not raise flag and requests");
  chk_chan4_force: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && (paddr == `TEVG_OFF_SWEV) && pwdata[4] |=> ##1 chan_flag[3])
    else $error("channel 4 force did not set its flag");
  chk_chan1_force: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && (paddr == `TEVG_OFF_SWEV) && pwdata[1]
    |=> st.swev[1] ##1 (chan_flag[0] && !st.swev[1]))
    else $error("channel 1 force was not a single event");
  chk_upd_oneshot: assert property (@(posedge pclk) disable iff (!presetn)
    st.swev[`TEVG_BIT_UPD] |=> !st.swev[`TEVG_BIT_UPD])
    else $error("update force bit did not clear itself");
  chk_uif_set: assert property (@(posedge pclk) disable iff (!presetn)
    st.swev[`TEVG_BIT_UPD] && !update_request_source_select && !update_disable_control |=> st.update_event_flag && st.upd_out)
    else $error("forced update did not set update flag");
  chk_uif_gated: assert property (@(posedge pclk) disable iff (!presetn)
    st.swev[`TEVG_BIT_UPD] && (update_disable_control || (update_request_source_select && !ovf)) |=> !st.upd_out)
    else $error("forced update made an event while disabled");
  chk_swev_reads0: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done && (paddr == `TEVG_OFF_SWEV) |-> st.prdata == 32'h0000_0000)
    else $error("event register read not zero");
  chk_zero_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && (paddr == `TEVG_OFF_SWEV) && (pwdata[6:0] == 7'h00) |=> st.swev == 7'h00)
    else $error("zero write requested an event");

  // The interrupt line follows the masked status one cycle later.
  chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    irq_src |=> st.irq)
    else $error("interrupt not raised for unmasked status");
  chk_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_src |=> !st.irq)
    else $error("interrupt raised with no unmasked status");

  // No event pulse leaves the block without its cause.
  chk_trig_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !st.swev[`TEVG_BIT_TRG] |=> !st.trig_out)
    else $error("trigger pulse without a trigger force");
  chk_upd_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !st.swev[`TEVG_BIT_UPD] && !ovf |=> !st.upd_out)
    else $error("update pulse without a cause");

  // Bus answer shape: ready is a one-cycle pulse and an error comes only with it.
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    st.pready |=> !st.pready)
    else $error("bus ready held longer than one cycle");
  chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    st.pslverr |-> st.pready)
    else $error("bus error without ready");

endmodule : tevg_top

/* File: verif/tevg_top_test.sv */
`timescale 1ns/1ps
`include "tevg_map.svh"
module tevg_top_test;
  // Clock, reset and bus drive.
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [6:0]  dma_req;
  logic        trig_out;
  logic        upd_out;
  int          error_cnt;
  int          checked;
  int          cycles;
  logic [31:0] rd;
  logic        er;

  tevg_top i_tevg_top (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .dma_req (dma_req),
    .trig_out(trig_out),
    .upd_out (upd_out)
  );

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // A hung handshake would stall the run, so a cycle ceiling ends it.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // One APB transfer; read data is taken at the edge where pready is sampled high.
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rd, er);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'h0, a, 32'h0000_0000, rd, er);
    chk(rd, exp, msg);
  endtask : rdc

  // Lets n edges pass and samples just after the last one.
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : step

  // Main sequence.
  initial begin
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rdc(`TEVG_OFF_SWEV, 32'h0, "event reg");
    rdc(`TEVG_OFF_ARR, 32'h0000_FFFF, "reload");
    apb(1'h0, 8'hFC, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    // Forced trigger, twice, with interrupt and DMA enabled.
    wr(`TEVG_OFF_MASK, 32'h40);
    wr(`TEVG_OFF_DMA, 32'h5F);
    for (int i = 0; i < 2; i++) begin
      wr(`TEVG_OFF_SWEV, 32'h40);
      step(1);
      chk({31'h0, trig_out}, 32'h1, "trigger pulse");
      chk({25'h0, dma_req}, 32'h40, "trigger dma");
      step(1);
      chk({31'h0, irq}, 32'h1, "trigger irq");
      chk({31'h0, trig_out}, 32'h0, "single pulse");
    end
    rdc(`TEVG_OFF_STATUS, 32'h40, "trigger flag");
    rdc(`TEVG_OFF_SWEV, 32'h0, "self clear");
    wr(`TEVG_OFF_STATUS, 32'h40);
    step(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(`TEVG_OFF_MASK, 32'h0);
    // Zero and reserved writes must do nothing.
    wr(`TEVG_OFF_SWEV, 32'h0);
    wr(`TEVG_OFF_SWEV, 32'hFFFF_FFA0);
    step(2);
    rdc(`TEVG_OFF_STATUS, 32'h0, "no event");
    // Down mode: a forced update loads the reload value into the stopped counter.
    wr(`TEVG_OFF_ARR, 32'h1234);
    wr(`TEVG_OFF_CTRL, 32'h02);
    wr(`TEVG_OFF_SWEV, 32'h01);
    step(1);
    chk({31'h0, upd_out}, 32'h1, "update pulse");
    chk({25'h0, dma_req}, 32'h01, "update dma");
    step(1);
    rdc(`TEVG_OFF_CNT, 32'h1234, "down reload");
    rdc(`TEVG_OFF_STATUS, 32'h01, "update flag");
    rdc(`TEVG_OFF_SWEV, 32'h0, "update self clear");
    wr(`TEVG_OFF_STATUS, 32'h01);
    // Output channels: flag and DMA, capture untouched although the count is not zero.
    for (int k = 1; k <= 4; k++) begin
      wr(`TEVG_OFF_SWEV, 32'h1 << k);
      step(1);
      chk({25'h0, dma_req}, 32'h1 << k, "channel dma");
      step(1);
      rdc(`TEVG_OFF_STATUS, 32'h1 << k, "channel flag");
      rdc(8'(`TEVG_OFF_CAP1 + 4 * (k - 1)), 32'h0, "no capture");
      wr(`TEVG_OFF_STATUS, 32'h1 << k);
    end
    // Two forced input captures on channel 1 set the overcapture flag.
    wr(`TEVG_OFF_CHDIR, 32'h1);
    wr(`TEVG_OFF_SWEV, 32'h02);
    wr(`TEVG_OFF_SWEV, 32'h02);
    step(2);
    rdc(`TEVG_OFF_STATUS, 32'h202, "overcapture");
    rdc(`TEVG_OFF_CAP1, 32'h1234, "captured count");
    wr(`TEVG_OFF_STATUS, 32'h1FFF);
    // Up and centre modes with a slow prescaler: the update restarts the count, and in up mode the prescale.
    wr(`TEVG_OFF_PSC, 32'hFF);
    wr(`TEVG_OFF_CTRL, 32'h01);
    step(700);
    wr(`TEVG_OFF_SWEV, 32'h01);
    step(2);
    rdc(`TEVG_OFF_CNT, 32'h0, "up clear");
    step(200);
    rdc(`TEVG_OFF_CNT, 32'h0, "prescale restart");
    rdc(`TEVG_OFF_PSC, 32'hFF, "ratio kept");
    wr(`TEVG_OFF_CTRL, 32'h05);
    step(600);
    wr(`TEVG_OFF_SWEV, 32'h01);
    step(2);
    rdc(`TEVG_OFF_CNT, 32'h0, "centre clear");
    wr(`TEVG_OFF_STATUS, 32'h01);
    // Update disable or source select suppresses flag, pulse and DMA request, not the counter reinit.
    for (int j = 0; j < 2; j++) begin
      wr(`TEVG_OFF_CTRL, (j == 0) ? 32'h09 : 32'h11);
      step(600);
      wr(`TEVG_OFF_SWEV, 32'h01);
      step(1);
      chk({31'h0, upd_out}, 32'h0, "gated pulse");
      step(1);
      rdc(`TEVG_OFF_STATUS, 32'h0, "gated flag");
      rdc(`TEVG_OFF_CNT, 32'h0, "gated reinit");
    end
    // A reset in mid-run returns the registers to their reset values.
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rdc(`TEVG_OFF_ARR, 32'h0000_FFFF, "reload after reset");
    rdc(`TEVG_OFF_CTRL, 32'h0, "control after reset");
    rdc(`TEVG_OFF_STATUS, 32'h0, "status after reset");
    report_and_stop();
  end
endmodule : tevg_top_test
